// >>> rtl/pcpwm_pkg.sv
package pcpwm_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_A = 8'h44;
  localparam logic [7:0] ADDR_CONTROL_A_IO = 8'h24;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h48;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h4c;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h50;
  localparam logic [7:0] ADDR_STATUS = 8'h54;
  localparam logic [7:0] ADDR_COUNT = 8'h58;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h5c;

  // Control A fields
  localparam int OUT_MODE_A_POS = 6;
  localparam int OUT_MODE_B_POS = 4;
  localparam int WAVE_LOW_POS = 0;
  localparam logic [7:0] CONTROL_A_MASK = 8'hf3;
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  // Control B fields
  localparam int WAVE_BIT2_POS = 3;
  localparam int PRESCALE_POS = 0;
  localparam logic [7:0] CONTROL_B_MASK = 8'h0f;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;

  // Status bits, write one to clear
  localparam int OVF_POS = 0;
  localparam int MATCH_A_POS = 1;
  localparam int MATCH_B_POS = 2;

  // Wave modes
  localparam logic [2:0] WAVE_PC_FULL = 3'h1;
  localparam logic [2:0] WAVE_PC_OCRA = 3'h5;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Output mode field values
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_NONINV = 2'h2;
  localparam logic [1:0] OUT_INV = 2'h3;

  // Prescaler selections and division ratios
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_DIV1 = 3'h1;
  localparam logic [2:0] PRE_DIV8 = 3'h2;
  localparam logic [2:0] PRE_DIV64 = 3'h3;
  localparam logic [2:0] PRE_DIV256 = 3'h4;
  localparam logic [2:0] PRE_DIV1024 = 3'h5;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03f;
  localparam logic [9:0] DIV256_LAST = 10'h0ff;
  localparam logic [9:0] DIV1024_LAST = 10'h3ff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRESP,
    BUS_RRESP
  } pcpwm_bus_e;

  // Whole block state
  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] compare_buf_a;
    logic [7:0] compare_buf_b;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] count_value;
    logic count_down;
    logic [9:0] prescale_count;
    logic overflow_flag;
    logic match_flag_a;
    logic match_flag_b;
    logic compare_out_a;
    logic compare_out_b;
    logic [1:0] pin_dir;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    pcpwm_bus_e bus;
    logic [1:0] resp;
    logic [31:0] rdata;
  } pcpwm_state_s;

endpackage : pcpwm_pkg

// >>> rtl/pcpwm_timer.sv
// Contract
// R01: Phase correct at mode 0x1 or 0x5
// R02: Count up to TOP, down to BOTTOM
// R03: Mode 0x1 uses TOP 0xFF
// R04: Mode 0x5 uses compare A as TOP
// R05: Field 0x2 clears up, sets down
// R06: Field 0x3 sets up, clears down
// R07: Hold TOP one tick then reverse
// R08: Overflow flag set at BOTTOM
// R09: Channel A toggles when bit2 set
// R10: Pin driven only when direction output
// R11: Extreme compare values give constant levels
// R12: Leaving MAX forces up-match level
// R13: Missed up match gives no change
// R14: Synchronous; tick only enables counting
// R15: Async base clock replaces bus clock; here aclk is the only clock
// R16: Tick divides by 1,8,64,256,1024
// R17: Control A at 0x44, alias 0x24
// R18: Field zero disconnects compare output
// R19: Compare equal TOP acts at TOP
// R20: Compare values load at TOP
// R21: Output changes only on tick
`timescale 1ns/1ps
`default_nettype none
module pcpwm_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare pins
  input wire logic [1:0] port_data,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic overflow_flag,
  output logic count_down_dir
);

  pcpwm_pkg::pcpwm_state_s st;
  pcpwm_pkg::pcpwm_state_s next_st;

  // Field decode used by several paths
  function automatic logic [2:0] wave_of(input logic [7:0] ca,
                                          input logic [7:0] cb);
    wave_of = {cb[pcpwm_pkg::WAVE_BIT2_POS],
               ca[pcpwm_pkg::WAVE_LOW_POS +: 2]};
  endfunction : wave_of

  // Output action for one channel at a tick
  function automatic logic chan_next(input logic cur,
                                     input logic [1:0] mode,
                                     input logic tog_ok,
                                     input logic hit,
                                     input logic down);
    chan_next = cur;
    if (hit) begin
      unique case (mode)
        pcpwm_pkg::OUT_TOGGLE: chan_next = tog_ok ? ~cur : cur;
        pcpwm_pkg::OUT_NONINV: chan_next = down;
        pcpwm_pkg::OUT_INV: chan_next = ~down;
        default: chan_next = cur;
      endcase
    end
  endfunction : chan_next

  logic [2:0] wave;
  logic pc_mode;
  logic [7:0] top;
  logic tick;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic [7:0] wr_addr;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic at_top;
  logic at_bottom;
  logic hit_a;
  logic hit_b;
  logic eff_down;

  // Decoded configuration
  // R01: mode decode
  assign wave = wave_of(st.control_a, st.control_b);
  assign pc_mode = (wave == pcpwm_pkg::WAVE_PC_FULL) ||
                   (wave == pcpwm_pkg::WAVE_PC_OCRA);
  // R03: fixed TOP
  // R04: compare A TOP
  assign top = (wave == pcpwm_pkg::WAVE_PC_OCRA) ? st.compare_value_a
                                                   : pcpwm_pkg::COUNT_MAX;
  assign mode_a = st.control_a[pcpwm_pkg::OUT_MODE_A_POS +: 2];
  assign mode_b = st.control_a[pcpwm_pkg::OUT_MODE_B_POS +: 2];
  assign at_top = st.count_value == top;
  assign at_bottom = st.count_value == pcpwm_pkg::COUNT_BOTTOM;

  // Prescaled tick, a clock enable only
  // R14: single clock
  // R16: divider ratios
  // R15: base clock is aclk here; an async source would feed aclk
  always_comb begin
    unique case (st.control_b[pcpwm_pkg::PRESCALE_POS +: 3])
      pcpwm_pkg::PRE_DIV1: tick = 1'b1;
      pcpwm_pkg::PRE_DIV8: tick = st.prescale_count[2:0] ==
                                   pcpwm_pkg::DIV8_LAST[2:0];
      pcpwm_pkg::PRE_DIV64: tick = st.prescale_count[5:0] ==
                                    pcpwm_pkg::DIV64_LAST[5:0];
      pcpwm_pkg::PRE_DIV256: tick = st.prescale_count[7:0] ==
                                     pcpwm_pkg::DIV256_LAST[7:0];
      pcpwm_pkg::PRE_DIV1024: tick = st.prescale_count ==
                                      pcpwm_pkg::DIV1024_LAST;
      default: tick = 1'b0;
    endcase
  end

  // Match with TOP special case: matched compare at TOP acts there
  // R19: act at TOP
  // R13: only equality matches, so a missed value changes nothing
  assign hit_a = tick && st.count_value == st.compare_value_a;
  assign hit_b = tick && st.count_value == st.compare_value_b;
  // Turning points act as one match: TOP as down, BOTTOM as up
  assign eff_down = at_top ? 1'b1 : (at_bottom ? 1'b0 : st.count_down);

  // Write channel join
  assign wr_addr = st.aw_addr;
  assign wr_fire = st.aw_held && st.w_held && st.bus == pcpwm_pkg::BUS_IDLE;
  assign wr_byte = st.w_strb[0] ? st.w_data[7:0] : 8'h00;

  // Next state
  always_comb begin
    next_st = st;
    // Prescaler keeps running while a source is selected
    if (st.control_b[pcpwm_pkg::PRESCALE_POS +: 3] == pcpwm_pkg::PRE_STOP)
      next_st.prescale_count = 10'h000;
    else
      next_st.prescale_count = st.prescale_count + 10'h001;

    // R21: tick gated
    if (pc_mode && tick) begin
      // R02: dual slope
      // R07: hold TOP one tick
      if (at_top && !st.count_down) begin
        next_st.count_down = 1'b1;
        // TOP stands one tick, so a period is 2 x TOP ticks
        next_st.count_value = st.count_value - 8'h01;
        // R20: buffer load at TOP
        next_st.compare_value_a = st.compare_buf_a;
        next_st.compare_value_b = st.compare_buf_b;
      end else if (st.count_down && at_bottom) begin
        next_st.count_down = 1'b0;
        next_st.count_value = st.count_value + 8'h01;
      end else if (st.count_down) begin
        next_st.count_value = st.count_value - 8'h01;
        // R08: overflow at BOTTOM
        if (st.count_value == 8'h01)
          next_st.overflow_flag = 1'b1;
      end else begin
        next_st.count_value = st.count_value + 8'h01;
      end
      // R05: non-inverted
      // R06: inverted
      // R09: toggle A only
      // R11: BOTTOM/MAX follow from equality
      next_st.compare_out_a = chan_next(st.compare_out_a, mode_a,
        st.control_b[pcpwm_pkg::WAVE_BIT2_POS], hit_a, eff_down);
      next_st.compare_out_b = chan_next(st.compare_out_b, mode_b, 1'b0,
        hit_b, eff_down);
      // R12: leaving MAX restores up-match level at TOP
      if (at_top && !st.count_down) begin
        if (st.compare_value_a == pcpwm_pkg::COUNT_MAX &&
            st.compare_buf_a != pcpwm_pkg::COUNT_MAX && mode_a[1])
          next_st.compare_out_a = mode_a[0];
        if (st.compare_value_b == pcpwm_pkg::COUNT_MAX &&
            st.compare_buf_b != pcpwm_pkg::COUNT_MAX && mode_b[1])
          next_st.compare_out_b = mode_b[0];
      end
      if (hit_a)
        next_st.match_flag_a = 1'b1;
      if (hit_b)
        next_st.match_flag_b = 1'b1;
    end else if (!pc_mode) begin
      // Other modes live elsewhere; park the counter
      next_st.count_down = 1'b0;
      next_st.compare_value_a = st.compare_buf_a;
      next_st.compare_value_b = st.compare_buf_b;
    end

    // Address and data channels, either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    unique case (st.bus)
      pcpwm_pkg::BUS_IDLE: begin
        if (wr_fire) begin
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.bus = pcpwm_pkg::BUS_WRESP;
          next_st.resp = pcpwm_pkg::RESP_OKAY;
          // R17: control A and its alias
          if (wr_addr == pcpwm_pkg::ADDR_CONTROL_A ||
              wr_addr == pcpwm_pkg::ADDR_CONTROL_A_IO) begin
            if (st.w_strb[0])
              next_st.control_a = wr_byte & pcpwm_pkg::CONTROL_A_MASK;
          end else if (wr_addr == pcpwm_pkg::ADDR_CONTROL_B) begin
            if (st.w_strb[0])
              next_st.control_b = wr_byte & pcpwm_pkg::CONTROL_B_MASK;
          end else if (wr_addr == pcpwm_pkg::ADDR_COMPARE_A) begin
            if (st.w_strb[0])
              next_st.compare_buf_a = wr_byte;
          end else if (wr_addr == pcpwm_pkg::ADDR_COMPARE_B) begin
            if (st.w_strb[0])
              next_st.compare_buf_b = wr_byte;
          end else if (wr_addr == pcpwm_pkg::ADDR_STATUS) begin
            // Set wins over clear in the same cycle
            if (wr_byte[pcpwm_pkg::OVF_POS] && !next_st.overflow_flag)
              next_st.overflow_flag = 1'b0;
            if (wr_byte[pcpwm_pkg::OVF_POS] && !(pc_mode && tick &&
                st.count_down && st.count_value == 8'h01))
              next_st.overflow_flag = 1'b0;
            if (wr_byte[pcpwm_pkg::MATCH_A_POS] && !hit_a)
              next_st.match_flag_a = 1'b0;
            if (wr_byte[pcpwm_pkg::MATCH_B_POS] && !hit_b)
              next_st.match_flag_b = 1'b0;
          end else if (wr_addr == pcpwm_pkg::ADDR_PIN_DIR) begin
            if (st.w_strb[0])
              next_st.pin_dir = wr_byte[1:0];
          end else if (wr_addr != pcpwm_pkg::ADDR_COUNT) begin
            next_st.resp = pcpwm_pkg::RESP_SLVERR;
          end
        end else if (s_axi_arvalid) begin
          next_st.bus = pcpwm_pkg::BUS_RRESP;
          next_st.resp = pcpwm_pkg::RESP_OKAY;
          next_st.rdata = 32'h0000_0000;
          if (s_axi_araddr == pcpwm_pkg::ADDR_CONTROL_A ||
              s_axi_araddr == pcpwm_pkg::ADDR_CONTROL_A_IO)
            next_st.rdata[7:0] = st.control_a;
          else if (s_axi_araddr == pcpwm_pkg::ADDR_CONTROL_B)
            next_st.rdata[7:0] = st.control_b;
          else if (s_axi_araddr == pcpwm_pkg::ADDR_COMPARE_A)
            next_st.rdata[7:0] = st.compare_buf_a;
          else if (s_axi_araddr == pcpwm_pkg::ADDR_COMPARE_B)
            next_st.rdata[7:0] = st.compare_buf_b;
          else if (s_axi_araddr == pcpwm_pkg::ADDR_STATUS)
            next_st.rdata[2:0] = {st.match_flag_b, st.match_flag_a,
                                  st.overflow_flag};
          else if (s_axi_araddr == pcpwm_pkg::ADDR_COUNT)
            next_st.rdata[8:0] = {st.count_down, st.count_value};
          else if (s_axi_araddr == pcpwm_pkg::ADDR_PIN_DIR)
            next_st.rdata[1:0] = st.pin_dir;
          else
            next_st.resp = pcpwm_pkg::RESP_SLVERR;
        end
      end
      pcpwm_pkg::BUS_WRESP: begin
        if (s_axi_bready)
          next_st.bus = pcpwm_pkg::BUS_IDLE;
      end
      pcpwm_pkg::BUS_RRESP: begin
        if (s_axi_rready)
          next_st.bus = pcpwm_pkg::BUS_IDLE;
      end
      default: next_st.bus = pcpwm_pkg::BUS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_st_reset: begin
        st <= '0;
        st.bus <= pcpwm_pkg::BUS_IDLE;
      end
    end else begin
      st <= next_st;
    end
  end

  // Bus handshakes
  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_arready = st.bus == pcpwm_pkg::BUS_IDLE && !wr_fire;
  assign s_axi_bvalid = st.bus == pcpwm_pkg::BUS_WRESP;
  assign s_axi_bresp = st.resp;
  assign s_axi_rvalid = st.bus == pcpwm_pkg::BUS_RRESP;
  assign s_axi_rresp = st.resp;
  assign s_axi_rdata = st.rdata;

  // Pin mux, compare overrides port when connected
  // R18: field zero disconnects
  // R10: direction gates driver
  assign pin_out[0] = (pc_mode && mode_a != pcpwm_pkg::OUT_OFF &&
                       !(mode_a == pcpwm_pkg::OUT_TOGGLE &&
                         !st.control_b[pcpwm_pkg::WAVE_BIT2_POS]))
                      ? st.compare_out_a : port_data[0];
  assign pin_out[1] = (pc_mode && mode_b[1]) ? st.compare_out_b
                                             : port_data[1];
  assign pin_oe = st.pin_dir;
  assign overflow_flag = st.overflow_flag;
  assign count_down_dir = st.count_down;

  // Assertions
  a_top_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && tick && at_top && !st.count_down |=>
    st.count_value == $past(st.count_value) - 8'h01 && st.count_down) // R07
    else $error("TOP not held one tick");
  a_no_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && st.count_down && at_bottom && tick |=> !st.count_down) // R02
    else $error("Counter wrapped below BOTTOM");
  a_bottom_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && tick && st.count_down && st.count_value == 8'h01
    |=> overflow_flag) // R08
    else $error("Overflow flag missed at BOTTOM");
  a_tick_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(st.compare_out_a) && $stable(st.count_value)) // R21
    else $error("Change without tick");
  a_noninv_up: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && hit_a && mode_a == pcpwm_pkg::OUT_NONINV && !st.count_down
    && !at_bottom && !at_top |=> !st.compare_out_a) // R05
    else $error("Non-inverted up match did not clear");
  a_inv_up: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && hit_b && mode_b == pcpwm_pkg::OUT_INV && !st.count_down
    && !at_bottom && !at_top |=> st.compare_out_b) // R06
    else $error("Inverted up match did not set");
  a_buf_load: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && tick && at_top && !st.count_down
    |=> st.compare_value_b == $past(st.compare_buf_b)) // R20
    else $error("Compare buffer not loaded at TOP");
  a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_oe == st.pin_dir) // R10
    else $error("Pin enable differs from direction");
  a_mode1_top: assert property (@(posedge aclk) disable iff (!aresetn)
    wave == pcpwm_pkg::WAVE_PC_FULL |-> top == pcpwm_pkg::COUNT_MAX) // R03
    else $error("Wrong TOP in full-range mode");

  c_reverse: cover property (@(posedge aclk) disable iff (!aresetn)
    pc_mode && at_top && tick ##1 st.count_down);
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(overflow_flag));
  c_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
    hit_a && mode_a == pcpwm_pkg::OUT_TOGGLE);

endmodule : pcpwm_timer
`default_nettype wire

// >>> tb/pcpwm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcpwm_pin_model (
  // Clock
  input wire logic aclk,
  // Pin side of the timer
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // Port latch level and resolved pad level
  output logic [1:0] port_data,
  output logic [1:0] pin_level
);
  // Port latch walks a pattern so a stale pass-through shows up
  initial port_data = 2'h0;
  always @(posedge aclk) begin
    port_data <= port_data + 2'h1;
  end

  // pad follows driver only when enabled
  // Undriven pads sit on the pull-up, never on a stale value
  assign pin_level[0] = pin_oe[0] ? pin_out[0] : 1'b1;
  assign pin_level[1] = pin_oe[1] ? pin_out[1] : 1'b1;
endmodule : pcpwm_pin_model
`default_nettype wire

// >>> tb/pcpwm_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, got, exp); \
  end \
end
module pcpwm_timer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ovf, dir;
  logic [1:0] bresp, rresp, port_data, pin_out, pin_oe, pin_level;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] er;
  logic [1:0] eb;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;

  pcpwm_timer dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe),
    .overflow_flag(ovf), .count_down_dir(dir)
  );

  pcpwm_pin_model pins_u (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_data(port_data), .pin_level(pin_level)
  );

  // Clock and cycle count
  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // Oldest note meets each bus answer
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      er = rq.pop_front();
      `CHK({rresp, rdata}, er)
    end
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK(bresp, eb)
    end
  end

  task automatic finish_test;
    $display("Counts: %0d checked, %0d errors", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic guard(inout int n, input int lim);
    n++;
    if (n > lim) begin
      num_errors++;
      $display("ERROR %0t: wait limit reached", $time);
      finish_test();
    end
  endtask : guard

  // Leading edge keeps two tasks from driving in one step
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n, 50);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n, 50);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : bus_rd

  task automatic cfg(input logic [1:0] oa, ob, input logic [2:0] wv, pre,
                     input logic [7:0] ca, cb);
    bus_wr(pcpwm_pkg::ADDR_COMPARE_A, {24'h0, ca}, pcpwm_pkg::RESP_OKAY);
    bus_wr(pcpwm_pkg::ADDR_COMPARE_B, {24'h0, cb}, pcpwm_pkg::RESP_OKAY);
    bus_wr(pcpwm_pkg::ADDR_CONTROL_B, {28'h0, wv[2], pre},
           pcpwm_pkg::RESP_OKAY);
    bus_wr(pcpwm_pkg::ADDR_CONTROL_A, {24'h0, oa, ob, 2'h0, wv[1:0]},
           pcpwm_pkg::RESP_OKAY);
  endtask : cfg

  // Cycle stamp of the next rise of direction (0) or overflow (1)
  task automatic wait_rise(input int sel, output int t);
    logic prev, cur;
    int n;
    n = 0;
    cur = sel ? ovf : dir;
    do begin
      prev = cur;
      @(posedge aclk);
      guard(n, 9000);
      cur = sel ? ovf : dir;
    end while (!(cur && !prev));
    t = cyc;
  endtask : wait_rise

  // First rise only settles the new top; overflow cleared between
  task automatic chk_period(input int sel, input int p);
    int t0, t1;
    wait_rise(0, t0);
    if (sel) bus_wr(pcpwm_pkg::ADDR_STATUS, 32'h1, pcpwm_pkg::RESP_OKAY);
    wait_rise(sel, t0);
    if (sel) bus_wr(pcpwm_pkg::ADDR_STATUS, 32'h1, pcpwm_pkg::RESP_OKAY);
    wait_rise(sel, t1);
    `CHK(t1 - t0, p)
  endtask : chk_period

  task automatic count_high(input int ch, input int n, input logic thru,
                            output int h);
    h = 0;
    repeat (n) begin
      @(posedge aclk);
      if (pin_out[ch] === 1'b1) h++;
      if (thru) `CHK(pin_out[ch], port_data[ch])
    end
  endtask : count_high

  initial begin
    logic [7:0] v, a, c;
    logic [1:0] p0;
    logic d0;
    int h, e;
    void'($urandom(49));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(pcpwm_pkg::ADDR_CONTROL_A, 32'h0, pcpwm_pkg::RESP_OKAY);
    bus_rd(8'h60, 32'h0, pcpwm_pkg::RESP_SLVERR);
    bus_wr(8'h60, 32'h5a, pcpwm_pkg::RESP_SLVERR);
    v = 8'($urandom());
    bus_wr(pcpwm_pkg::ADDR_CONTROL_A_IO, {24'h0, v}, pcpwm_pkg::RESP_OKAY);
    bus_rd(pcpwm_pkg::ADDR_CONTROL_A, {24'h0, v & pcpwm_pkg::CONTROL_A_MASK},
           pcpwm_pkg::RESP_OKAY);
    // pads driven only when direction is output
    `CHK(pin_level, 2'h3)
    bus_wr(pcpwm_pkg::ADDR_PIN_DIR, 32'h3, pcpwm_pkg::RESP_OKAY);
    @(posedge aclk);
    `CHK(pin_level, pin_out)
    $display("registers and pins done");
    a = 8'($urandom_range(200, 20));
    cfg(pcpwm_pkg::OUT_NONINV, pcpwm_pkg::OUT_NONINV,
        pcpwm_pkg::WAVE_PC_FULL, pcpwm_pkg::PRE_DIV8, 8'h40, 8'h10);
    chk_period(0, 4080);
    cfg(pcpwm_pkg::OUT_NONINV, pcpwm_pkg::OUT_NONINV,
        pcpwm_pkg::WAVE_PC_FULL, pcpwm_pkg::PRE_DIV1, 8'h40, 8'h10);
    chk_period(1, 510);
    cfg(pcpwm_pkg::OUT_NONINV, pcpwm_pkg::OUT_NONINV,
        pcpwm_pkg::WAVE_PC_OCRA, pcpwm_pkg::PRE_DIV1, a, 8'h10);
    chk_period(0, 2 * a);
    count_high(1, 2 * a, 1'b0, h);
    `CHK(h, 32)
    $display("periods done");
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        c = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom_range(254, 1));
        cfg(m ? pcpwm_pkg::OUT_INV : pcpwm_pkg::OUT_NONINV,
            m ? pcpwm_pkg::OUT_INV : pcpwm_pkg::OUT_NONINV,
            pcpwm_pkg::WAVE_PC_FULL, pcpwm_pkg::PRE_DIV1, c, c);
        repeat (1100) @(posedge aclk);
        e = m ? 510 - 2 * c : 2 * c;
        count_high(0, 510, 1'b0, h);
        `CHK(h, e)
        count_high(1, 510, 1'b0, h);
        `CHK(h, e)
      end
    end
    $display("duty done");
    // toggle needs bit2 and only on channel A
    cfg(pcpwm_pkg::OUT_TOGGLE, pcpwm_pkg::OUT_OFF,
        pcpwm_pkg::WAVE_PC_FULL, pcpwm_pkg::PRE_DIV1, 8'h40, 8'h40);
    repeat (600) @(posedge aclk);
    count_high(0, 600, 1'b1, h);
    count_high(1, 600, 1'b1, h);
    cfg(pcpwm_pkg::OUT_TOGGLE, pcpwm_pkg::OUT_TOGGLE,
        pcpwm_pkg::WAVE_PC_OCRA, pcpwm_pkg::PRE_DIV1, a, 8'h10);
    repeat (1100) @(posedge aclk);
    count_high(0, 4 * a, 1'b0, h);
    `CHK(h, 2 * a)
    count_high(1, 600, 1'b1, h);
    $display("toggle done");
    // stopped tick freezes count direction and pins
    cfg(pcpwm_pkg::OUT_NONINV, pcpwm_pkg::OUT_NONINV,
        pcpwm_pkg::WAVE_PC_FULL, pcpwm_pkg::PRE_STOP, 8'h80, 8'h80);
    repeat (4) @(posedge aclk);
    d0 = dir;
    p0 = pin_out;
    repeat (600) @(posedge aclk);
    `CHK({dir, pin_out}, {d0, p0})
    $display("stop done");
    finish_test();
  end
endmodule : pcpwm_timer_tb
`default_nettype wire
